// ===== nv_sram_store_recall_port_test.sv
// Purpose: Self-checking bench for the nonvolatile memory host controller.
// Assumes: Short nonvolatile waits of 20 cycles; inputs change on falling edges.
// Notes: Each scenario is one task.
`timescale 1ns/1ns

module nv_sram_store_recall_port_test;
   localparam int WAIT_CYC = 20; // Shortened power-up, store and recall waits.
   localparam int RSP_LAT = 6; // Edges from the take until the response pulse shows at a falling edge.
   logic mclk_in, reset_n_in, req_valid, req_ready, rsp_valid, ce_n, we_n, oe_n;
   logic bus_oe, hsb_n, hsb_pull_n, nv_busy;
   logic [1:0] req_kind;
   logic [16:0] req_addr, sram_addr;
   logic [7:0] req_wdata, rsp_rdata, bus_in, bus_out, store_cnt, recall_cnt;
   int err_count = 0;
   int check_count = 0;
   int wt, lat;

   nvsram_host #(.RECALL_PWRUP_CYCLES(WAIT_CYC), .STORE_CYCLES(WAIT_CYC), .RECALL_SW_CYCLES(WAIT_CYC)) i_dut (
      .mclk_in(mclk_in), .reset_n_in(reset_n_in), .req_valid_in(req_valid), .req_kind_in(req_kind),
      .req_addr_in(req_addr), .req_wdata_in(req_wdata), .req_ready_out(req_ready), .rsp_valid_out(rsp_valid),
      .rsp_rdata_out(rsp_rdata), .sram_ce_n_out(ce_n), .sram_we_n_out(we_n), .sram_oe_n_out(oe_n),
      .sram_addr_out(sram_addr), .data_bus_in(bus_in), .data_bus_out(bus_out), .data_bus_oe_out(bus_oe),
      .hw_store_busy_n_in(hsb_n), .nv_busy_out(nv_busy));

   nvsram_dev_model i_dev (
      .ce_n_in(ce_n), .we_n_in(we_n), .oe_n_in(oe_n), .addr_in(sram_addr), .host_data_in(bus_out),
      .host_oe_in(bus_oe), .hsb_pull_n_in(hsb_pull_n), .data_bus_out(bus_in), .hw_store_busy_n_out(hsb_n),
      .store_cnt_out(store_cnt), .recall_cnt_out(recall_cnt));

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   // Counts a comparison and reports a mismatch.
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   // Prints the verdict and ends the run.
   task automatic stop_test();
      if (err_count == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : stop_test

   // One request; wt is cycles until taken, lat the response or busy cycles.
   task automatic do_req(input logic [1:0] k, input logic [16:0] a, input logic [7:0] d,
                         output int wt, output int lat);
      logic got;
      int n;
      wt = 0;
      lat = 0;
      got = 1'b0;
      @(negedge mclk_in);
      req_valid = 1'b1;
      req_kind = k;
      req_addr = a;
      req_wdata = d;
      while (!got && wt < 5000) begin
         #45;
         got = (req_ready === 1'b1);
         @(posedge mclk_in);
         wt++;
         if (!got) @(negedge mclk_in);
      end
      chk("taken", got, 1'b1);
      @(negedge mclk_in);
      req_valid = 1'b0;
      if (k < 2'h2) begin
         while (lat < 30 && rsp_valid !== 1'b1) begin
            @(posedge mclk_in);
            lat++;
            @(negedge mclk_in);
         end
      end else begin
         // Six reads take about 36 cycles; then wait for both busy signals.
         for (n = 0; n < 400 && (n < 60 || nv_busy !== 1'b0 || hsb_n !== 1'b1); n++) begin
            @(negedge mclk_in);
            if (nv_busy === 1'b1) lat++;
         end
      end
   endtask : do_req

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   // First read waits out power-up and sees the recalled blank array.
   task automatic t_powerup();
      do_req(2'h0, 17'h00555, 8'h00, wt, lat);
      chk("pwrup_wait", wt >= WAIT_CYC, 1'b1);
      chk("pwrup_data", rsp_rdata, 8'h00);
      chk("read_lat", lat, RSP_LAT);
   endtask : t_powerup

   // Writes and reads back at both ends of the address range.
   task automatic t_wr_rd();
      logic [16:0] a [2] = '{17'h00000, 17'h1ffff};
      logic [7:0] d [2] = '{8'h3c, 8'hc3};
      foreach (a[i]) begin
         do_req(2'h1, a[i], d[i], wt, lat);
         chk("write_lat", lat, RSP_LAT);
         do_req(2'h0, a[i], 8'h00, wt, lat);
         chk("read_lat", lat, RSP_LAT);
         chk("read_data", rsp_rdata, d[i]);
      end
   endtask : t_wr_rd

   // Store, a skipped store, an overwrite, then recall restores the byte.
   task automatic t_store_recall();
      int busy1;
      do_req(2'h1, 17'h00100, 8'h11, wt, lat);
      do_req(2'h2, 17'h00000, 8'h00, wt, busy1);
      chk("store_busy", busy1 >= WAIT_CYC - 1, 1'b1);
      chk("store_cnt", store_cnt, 8'h01);
      do_req(2'h2, 17'h00000, 8'h00, wt, lat);
      chk("store_skip", lat < busy1, 1'b1);
      chk("store_cnt2", store_cnt, 8'h01);
      do_req(2'h1, 17'h00100, 8'h22, wt, lat);
      do_req(2'h0, 17'h00100, 8'h00, wt, lat);
      chk("overwrite", rsp_rdata, 8'h22);
      do_req(2'h3, 17'h00000, 8'h00, wt, lat);
      chk("recall_cnt", recall_cnt, 8'h01);
      do_req(2'h0, 17'h00100, 8'h00, wt, lat);
      chk("recall_data", rsp_rdata, 8'h11);
   endtask : t_store_recall

   // A low busy line holds off a read request until it rises.
   task automatic t_hsb();
      @(negedge mclk_in);
      hsb_pull_n = 1'b0;
      req_valid = 1'b1;
      req_kind = 2'h0;
      for (int i = 0; i < 5; i++) begin
         #45;
         chk("hsb_refuse", req_ready, 1'b0);
         chk("hsb_no_select", ce_n, 1'b1);
         @(negedge mclk_in);
      end
      // Withdraw the held request first, so the release does not start a stray read.
      req_valid = 1'b0;
      hsb_pull_n = 1'b1;
      do_req(2'h0, 17'h1ffff, 8'h00, wt, lat);
      chk("hsb_after", rsp_rdata, 8'hc3);
   endtask : t_hsb

   // ****************************************************************
   // Clock, sequence and watchdog
   // ****************************************************************
   initial begin
      mclk_in = 1'b0;
      forever #50 mclk_in = ~mclk_in;
   end

   initial begin
      reset_n_in = 1'b0;
      req_valid = 1'b0;
      req_kind = 2'h0;
      req_addr = 17'h00000;
      req_wdata = 8'h00;
      hsb_pull_n = 1'b1;
      repeat (5) @(posedge mclk_in);
      chk("rst_strobes", {ce_n, we_n, oe_n, bus_oe, req_ready}, 5'h1c);
      @(negedge mclk_in);
      reset_n_in = 1'b1;
      t_powerup();
      t_wr_rd();
      t_store_recall();
      t_hsb();
      stop_test();
   end

   // The whole run needs a few hundred cycles; this cuts off a hang.
   initial begin
      #5000000;
      err_count++;
      stop_test();
   end
endmodule : nv_sram_store_recall_port_test

// ===== nvsram_dev_model.sv
// Purpose: Behavioural nonvolatile static memory facing the host controller.
// Assumes: Active-low strobes; the data bus is resolved here with a 1 ns lag.
// Notes: The command sequence is sampled on select falls only.
`timescale 1ns/1ns

module nvsram_dev_model #(
   parameter int PWRUP_NS = 1500,
   parameter int STORE_NS = 1500,
   parameter int RECALL_NS = 1000
) (
   input wire logic ce_n_in,
   input wire logic we_n_in,
   input wire logic oe_n_in,
   input wire logic [16:0] addr_in,
   input wire logic [7:0] host_data_in,
   input wire logic host_oe_in,
   input wire logic hsb_pull_n_in,
   output logic [7:0] data_bus_out,
   output logic hw_store_busy_n_out,
   output logic [7:0] store_cnt_out,
   output logic [7:0] recall_cnt_out
);
   // ****************************************************************
   // State
   // ****************************************************************
   logic [7:0] sram_q [0:131071]; // Volatile array.
   logic [7:0] nv_q [0:131071]; // Nonvolatile copy.
   logic busy_q; // Store or recall running.
   logic store_q; // Store running, shown on the busy line.
   logic dirty_q; // Written since the last nonvolatile cycle.
   logic float_q; // Select fell with write low.
   logic [2:0] idx_q; // Command sequence position.
   logic [7:0] wander_q; // Undriven bus pattern, so a stale value never passes.
   wire drive = !ce_n_in && !oe_n_in && we_n_in && !busy_q && !float_q;
   wire wr_act = !ce_n_in && !we_n_in;

   // Bus lags the strobes so a write still sees its data at the strobe rise.
   assign #1 data_bus_out = host_oe_in ? host_data_in : (drive ? sram_q[addr_in] : wander_q);
   assign hw_store_busy_n_out = hsb_pull_n_in & ~store_q;

   // Expected sequence address for a position.
   function automatic logic [15:0] seq_at(input logic [2:0] i);
      case (i)
         3'h0: seq_at = 16'h4e38;
         3'h1: seq_at = 16'hb1c7;
         3'h2: seq_at = 16'h83e0;
         3'h3: seq_at = 16'h7c1f;
         default: seq_at = 16'h703f;
      endcase
   endfunction : seq_at

   // Power-up recall ends before the host's own wait runs out.
   initial begin
      busy_q = 1'b1;
      store_q = 1'b0;
      dirty_q = 1'b0;
      float_q = 1'b0;
      idx_q = 3'h0;
      wander_q = 8'h5a;
      store_cnt_out = 8'h00;
      recall_cnt_out = 8'h00;
      foreach (nv_q[i]) nv_q[i] = 8'h00;
      #(PWRUP_NS);
      sram_q = nv_q;
      busy_q = 1'b0;
   end

   // The floating bus changes often, unrelated to the clock.
   always #37 wander_q = ~wander_q;

   // A write lands at its end unless a store or recall is running; each write that lands restarts the sequence.
   always @(negedge wr_act) begin
      if ($time > 0 && !busy_q) begin
         sram_q[addr_in] = data_bus_out;
         dirty_q = 1'b1;
         idx_q = 3'h0;
      end
   end

   // Select fall: settle 1 ns, then step the sequence detector.
   always @(negedge ce_n_in) begin
      #1;
      float_q = !we_n_in;
      if (we_n_in && !busy_q) begin
         if (idx_q == 3'h5) begin
            idx_q = 3'h0;
            if (addr_in[15:0] == 16'h8fc0 && dirty_q) begin
               busy_q = 1'b1;
               store_q = 1'b1;
               #(STORE_NS);
               nv_q = sram_q;
               store_cnt_out = store_cnt_out + 8'h01;
               dirty_q = 1'b0;
               store_q = 1'b0;
               busy_q = 1'b0;
            end else if (addr_in[15:0] == 16'h4c63) begin
               busy_q = 1'b1;
               #(RECALL_NS);
               sram_q = nv_q;
               recall_cnt_out = recall_cnt_out + 8'h01;
               dirty_q = 1'b0;
               busy_q = 1'b0;
            end
         end else if (addr_in[15:0] == seq_at(idx_q)) begin
            idx_q = idx_q + 3'h1;
         end else begin
            idx_q = (addr_in[15:0] == 16'h4e38) ? 3'h1 : 3'h0;
         end
      end
   end

   // Deselect ends the float hold.
   always @(posedge ce_n_in) float_q = 1'b0;
endmodule : nvsram_dev_model

// ===== nvsram_host.sv
// Purpose: Host controller driving a byte-wide nonvolatile static memory.
// Assumes: Pins sampled synchronously to mclk_in; data bus three-signal form.
// Notes: Each access is a chip-select controlled cycle of two phases.
`timescale 1ns/1ns
`include "nvsram_host_defines.svh"

// Notes on behaviour
// - Write strobe stays high during reads.
// - Access only while store-busy line high; checked only at acceptance, later command reads do not wait for it.
// - Address changes only with select or write high.
// - Command is six consecutive reads, write high.
// - Low 16 bits decode store and recall sequences.
module nvsram_host #(
   parameter int ADDR_W = 17,
   parameter bit INDUSTRIAL = 1'b0,
   parameter int RECALL_PWRUP_CYCLES = `RECALL_PWRUP_CYC,
   parameter int STORE_CYCLES = INDUSTRIAL ? `STORE_IND_CYC : `STORE_CYC,
   parameter int RECALL_SW_CYCLES = `RECALL_SW_CYC
) (
   input wire logic mclk_in,
   input wire logic reset_n_in,
   input wire logic req_valid_in,
   input wire logic [1:0] req_kind_in,
   input wire logic [ADDR_W-1:0] req_addr_in,
   input wire logic [7:0] req_wdata_in,
   output logic req_ready_out,
   output logic rsp_valid_out,
   output logic [7:0] rsp_rdata_out,
   output logic sram_ce_n_out,
   output logic sram_we_n_out,
   output logic sram_oe_n_out,
   output logic [ADDR_W-1:0] sram_addr_out,
   input wire logic [7:0] data_bus_in,
   output logic [7:0] data_bus_out,
   output logic data_bus_oe_out,
   input wire logic hw_store_busy_n_in,
   output logic nv_busy_out
);
   // ****************************************************************
   // Types and state
   // ****************************************************************
   // Controller states: power-up wait, idle, select phase, release phase, nonvolatile wait.
   typedef enum logic [2:0] {
      st_powerup,
      st_idle,
      st_active,
      st_release,
      st_nvwait
   } state_e;

   localparam int TW = 24;

   state_e state_q;
   state_e state_d;
   // Current access kind and address latched at acceptance.
   logic is_write_q;
   logic [ADDR_W-1:0] addr_q;
   logic [7:0] wdata_q;
   // Command step index inside the six-read sequence.
   logic [2:0] step_q;
   logic [2:0] step_d;
   logic cmd_store_q;
   logic [3:0] phase_q;
   logic [7:0] rdata_q;
   logic rsp_q;
   // Set by any write; a store with this clear needs no wait.
   logic dirty_q;
   // Timer control.
   logic tmr_load;
   logic [TW-1:0] tmr_count;
   logic tmr_busy;
   logic tmr_done;

   // ****************************************************************
   // Decode
   // ****************************************************************
   wire logic accept;
   wire logic phase_end;
   wire logic access_start;
   wire logic seq_last;
   wire logic [ADDR_W-1:0] seq_addr;
   wire logic [ADDR_W-1:0] seq_final;
   wire logic is_cmd;
   wire logic hsb_ok;
   // Kind of the access that starts now; on an accept the latch still holds the previous one.
   wire logic wr_next;

   assign hsb_ok = hw_store_busy_n_in;
   assign req_ready_out = (state_q == st_idle) && hsb_ok && !rsp_q;
   assign accept = req_valid_in && req_ready_out;
   assign is_cmd = (req_kind_in == nvsram_host_pkg::req_store) || (req_kind_in == nvsram_host_pkg::req_recall);
   assign wr_next = accept ? (req_kind_in == nvsram_host_pkg::req_write) : is_write_q;
   assign phase_end = (phase_q == `PHASE_CYC);
   // Steps one to six are the six command reads; step zero is a plain access.
   assign seq_last = (step_q == 3'h6);
   assign seq_final = cmd_store_q ? `SEQ_STORE : `SEQ_RECALL;
   // Sequence table; the top address bit is left zero since only 16 bits decode.
   assign seq_addr = (step_q == 3'h0) ? `SEQ_A0 :
                     (step_q == 3'h1) ? `SEQ_A1 :
                     (step_q == 3'h2) ? `SEQ_A2 :
                     (step_q == 3'h3) ? `SEQ_A3 :
                     (step_q == 3'h4) ? `SEQ_A4 : seq_final;
   assign access_start = (state_q == st_release) && phase_end && (step_q != 3'h0) && !seq_last;
   assign tmr_count = (state_q == st_powerup) ? TW'(RECALL_PWRUP_CYCLES) :
                      cmd_store_q ? TW'(STORE_CYCLES) : TW'(RECALL_SW_CYCLES);
   assign tmr_load = ((state_q == st_powerup) && !tmr_busy && (phase_q == 4'h0)) ||
                     ((state_q == st_release) && phase_end && seq_last && step_q != 3'h0 &&
                      (!cmd_store_q || dirty_q));

   // ****************************************************************
   // Next state
   // ****************************************************************
   // Sequencing of accesses; every command access is a read, so write strobe stays high.
   always_comb begin
      state_d = state_q;
      step_d = step_q;
      unique case (state_q)
         st_powerup: begin
            // Wait out the longest recall before any access.
            if (tmr_done) begin
               state_d = st_idle;
            end
         end
         st_idle: begin
            if (accept) begin
               state_d = st_active;
               step_d = is_cmd ? 3'h1 : 3'h0;
            end
         end
         st_active: begin
            if (phase_end) begin
               state_d = st_release;
            end
         end
         st_release: begin
            if (phase_end) begin
               if (step_q == 3'h0) begin
                  state_d = st_idle;
               end else if (seq_last) begin
                  // A store with nothing written is skipped and no wait is needed.
                  state_d = (!cmd_store_q || dirty_q) ? st_nvwait : st_idle;
                  step_d = 3'h0;
               end else begin
                  state_d = st_active;
                  step_d = step_q + 3'h1;
               end
            end
         end
         st_nvwait: begin
            // No access is issued until the store or recall bound expires.
            if (tmr_done) begin
               state_d = st_idle;
            end
         end
         default: begin
            state_d = st_idle;
         end
      endcase
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   // State, step and phase counter.
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_q <= st_powerup;
         step_q <= 3'h0;
         phase_q <= 4'h0;
      end else begin
         state_q <= state_d;
         step_q <= step_d;
         phase_q <= (state_q != state_d || phase_end || state_q == st_idle) ? 4'h0 :
                    (state_q == st_powerup) ? 4'h1 : phase_q + 4'h1;
      end
   end

   // Request capture.
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         is_write_q <= 1'b0;
         addr_q <= '0;
         wdata_q <= 8'h00;
         cmd_store_q <= 1'b0;
      end else if (accept) begin
         is_write_q <= (req_kind_in == nvsram_host_pkg::req_write);
         addr_q <= req_addr_in;
         wdata_q <= req_wdata_in;
         cmd_store_q <= (req_kind_in == nvsram_host_pkg::req_store);
      end
   end

   // Written-since-store tracking; a write sets it, a started store clears it.
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         dirty_q <= 1'b1;
      end else if (accept && req_kind_in == nvsram_host_pkg::req_write) begin
         dirty_q <= 1'b1;
      end else if (tmr_load && cmd_store_q && state_q == st_release) begin
         dirty_q <= 1'b0;
      end
   end

   // Read data capture at the end of the select phase, and response pulse.
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rdata_q <= 8'h00;
         rsp_q <= 1'b0;
      end else begin
         rsp_q <= (state_q == st_release) && phase_end && (step_q == 3'h0);
         if (state_q == st_active && phase_end && !is_write_q && step_q == 3'h0) begin
            rdata_q <= data_bus_in;
         end
      end
   end

   // ****************************************************************
   // Pins
   // ****************************************************************
   // Address is held through select and release; it moves on acceptance in idle and at the end of release before the next command read.
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sram_addr_out <= '0;
      end else if (accept && !is_cmd) begin
         sram_addr_out <= req_addr_in;
      end else if ((accept && is_cmd) || access_start) begin
         sram_addr_out <= (accept && is_cmd) ? `SEQ_A0 : seq_addr;
      end
   end

   // Strobes: select and write fall on the same edge for writes, with output enable high, so the device never drives.
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sram_ce_n_out <= 1'b1;
         sram_we_n_out <= 1'b1;
         sram_oe_n_out <= 1'b1;
         data_bus_out <= 8'h00;
         data_bus_oe_out <= 1'b0;
      end else begin
         sram_ce_n_out <= !(state_d == st_active);
         sram_we_n_out <= !(state_d == st_active && wr_next && step_d == 3'h0);
         sram_oe_n_out <= !(state_d == st_active && !(wr_next && step_d == 3'h0));
         data_bus_out <= (accept) ? req_wdata_in : wdata_q;
         data_bus_oe_out <= (state_d == st_active) && wr_next && (step_d == 3'h0);
      end
   end

   assign rsp_valid_out = rsp_q;
   assign rsp_rdata_out = rdata_q;
   assign nv_busy_out = tmr_busy;

   // Bounded wait for power-up recall, store and recall.
   nvsram_wait_timer #(
      .WIDTH(TW)
   ) u_timer (
      .mclk_in(mclk_in),
      .reset_n_in(reset_n_in),
      .load_in(tmr_load),
      .count_in(tmr_count),
      .busy_out(tmr_busy),
      .done_out(tmr_done)
   );

   // ****************************************************************
   // Checks
   // ****************************************************************
   property p_we_high_read;
      @(posedge mclk_in) disable iff (!reset_n_in)
      (!sram_ce_n_out && !sram_oe_n_out) |-> sram_we_n_out;
   endproperty
   a_we_high_read: assert property (p_we_high_read) else $error("write strobe low in read");

   property p_no_access_busy;
      @(posedge mclk_in) disable iff (!reset_n_in)
      tmr_busy |-> sram_ce_n_out;
   endproperty
   a_no_access_busy: assert property (p_no_access_busy) else $error("access during nonvolatile wait");

   property p_addr_stable;
      @(posedge mclk_in) disable iff (!reset_n_in)
      (!sram_ce_n_out && !sram_we_n_out && !$past(sram_ce_n_out) && !$past(sram_we_n_out)) |->
         $stable(sram_addr_out);
   endproperty
   a_addr_stable: assert property (p_addr_stable) else $error("address moved during write");

   property p_write_drive;
      @(posedge mclk_in) disable iff (!reset_n_in)
      $fell(sram_ce_n_out) && !sram_we_n_out |-> data_bus_oe_out && sram_oe_n_out;
   endproperty
   a_write_drive: assert property (p_write_drive) else $error("write without host drive");

   property p_cmd_reads;
      @(posedge mclk_in) disable iff (!reset_n_in)
      (state_q == st_active && step_q != 3'h0) |-> sram_we_n_out && !data_bus_oe_out;
   endproperty
   a_cmd_reads: assert property (p_cmd_reads) else $error("command access not a read");

   property p_final_addr;
      @(posedge mclk_in) disable iff (!reset_n_in)
      (state_q == st_active && step_q == 3'h6) |-> sram_addr_out[15:0] == seq_final[15:0];
   endproperty
   a_final_addr: assert property (p_final_addr) else $error("wrong final command address");

   property p_clean_store;
      @(posedge mclk_in) disable iff (!reset_n_in)
      (state_q == st_release && phase_end && seq_last && cmd_store_q && !dirty_q) |=> state_q == st_idle;
   endproperty
   a_clean_store: assert property (p_clean_store) else $error("clean store waited");

   property p_hsb;
      @(posedge mclk_in) disable iff (!reset_n_in)
      !hw_store_busy_n_in |-> !req_ready_out;
   endproperty
   a_hsb: assert property (p_hsb) else $error("ready while store busy low");
endmodule : nvsram_host

// ===== nvsram_host_defines.svh
// Purpose: Constants for the nonvolatile static memory host controller.
// Assumes: 10 MHz clock, 100 ns period.
// Notes: Times are kept in their own unit; cycle counts derive from them.
`ifndef NVSRAM_HOST_DEFINES_SVH
`define NVSRAM_HOST_DEFINES_SVH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define CLK_PERIOD_NS 100
`define RECALL_PWRUP_MS 20
`define STORE_MAX_US 12500
`define STORE_MAX_IND_US 15000
`define RECALL_SW_US 50
// Waits are upper bounds, rounded down, never below one cycle.
`define RECALL_PWRUP_CYC ((`RECALL_PWRUP_MS * 1000000) / `CLK_PERIOD_NS)
`define STORE_CYC ((`STORE_MAX_US * 1000) / `CLK_PERIOD_NS)
`define STORE_IND_CYC ((`STORE_MAX_IND_US * 1000) / `CLK_PERIOD_NS)
`define RECALL_SW_CYC ((`RECALL_SW_US * 1000) / `CLK_PERIOD_NS)
// Last phase count value; each access phase lasts one clock cycle more, three cycles (300 ns each, above any cycle time).
`define PHASE_CYC 4'h2

// ****************************************************************
// Command sequence addresses, low 16 bits significant
// ****************************************************************
`define SEQ_A0 17'h04e38
`define SEQ_A1 17'h0b1c7
`define SEQ_A2 17'h083e0
`define SEQ_A3 17'h07c1f
`define SEQ_A4 17'h0703f
`define SEQ_STORE 17'h08fc0
`define SEQ_RECALL 17'h04c63

`endif

// ===== nvsram_host_pkg.sv
// Purpose: Types for the nonvolatile static memory host controller.
// Assumes: Used with nvsram_host_defines.svh.
// Notes: Holds only types.
package nvsram_host_pkg;
   // Request kinds accepted from the user side.
   typedef enum logic [1:0] {
      req_read,
      req_write,
      req_store,
      req_recall
   } req_e;
endpackage : nvsram_host_pkg

// ===== nvsram_wait_timer.sv
// Purpose: Down counter bounding the wait for a nonvolatile cycle.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Load sets the count; done pulses when it reaches one.
`timescale 1ns/1ns
`include "nvsram_host_defines.svh"

module nvsram_wait_timer #(
   parameter int WIDTH = 24
) (
   input wire logic mclk_in,
   input wire logic reset_n_in,
   input wire logic load_in,
   input wire logic [WIDTH-1:0] count_in,
   output logic busy_out,
   output logic done_out
);
   // Remaining cycles; zero means idle.
   logic [WIDTH-1:0] cnt_q;
   logic [WIDTH-1:0] cnt_d;

   // Reload wins over counting so a new wait never inherits an old one.
   assign cnt_d = load_in ? count_in : (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
   assign busy_out = (cnt_q != '0);
   assign done_out = (cnt_q == {{(WIDTH-1){1'b0}}, 1'b1});

   // ****************************************************************
   // Counter register
   // ****************************************************************
   // Plain register; all decisions sit in the assignments above.
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end
endmodule : nvsram_wait_timer
